// ### gpio_bank_pin_control.v
/*
  One 32-pin GPIO bank: register file, pad drive and pad sampling,
  reached over an AHB-Lite slave port with zero wait states.
  Assumes the pads are resolved outside from pin_out and pin_oe, and
  that pin_in is asynchronous to clk; it is synchronised here.
  Assumes a single slave on its bus, so hready is this slave's own
  hreadyout fed back by the interconnect.
  Assumes alt_out and alt_oe come from logic on the same clock.
  A second bank is a second instance of this module; it shares no
  state with the first.
*/
// Operation
// - pins 0-15 output-select 2-bit field in low register; 00 selects latch.
// - pins 16-31 select fields in high registers, pin 16 at bits 0:1.
// - per-pin 2-bit three-state select; 00 lets control bit drive enable.
// - latch 0 with control 1 drives the pin low.
// - latch 1 with control 1 drives the pin high unless its open-drain bit is set.
// - control 0 floats the pin regardless of latch.
// - input register bit n reads the level of pin n, delayed by the two-stage synchroniser.
// - pin n maps to bit n of latch, control, open-drain, input registers.
// - a second bank repeats the identical scheme for the next pins.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_map.vh"

module gpio_bank_pin_control #(
  parameter PINS = 32
) (
  // clock, reset, enable
  input  wire              clk,
  input  wire              rst,
  input  wire              ce,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  // alternate function source, used when a select field is not 00
  input  wire [PINS-1:0]   alt_out,
  input  wire [PINS-1:0]   alt_oe,
  // pads
  input  wire [PINS-1:0]   pin_in,
  output reg  [PINS-1:0]   pin_out,
  output reg  [PINS-1:0]   pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  // software-visible registers
  reg  [31:0]     output_latch_q;
  reg  [31:0]     output_enable_control_q;
  reg  [31:0]     output_select_low_q;
  reg  [31:0]     output_select_high_q;
  reg  [31:0]     tristate_select_low_q;
  reg  [31:0]     tristate_select_high_q;
  reg  [31:0]     open_drain_enable_q;

  // pin input synchroniser
  reg  [PINS-1:0] sync1_q;
  reg  [PINS-1:0] sync2_q;

  // bus data phase bookkeeping
  reg             wr_pend_q;
  reg  [7:0]      wr_addr_q;

  // next values of the pads and of the read data
  wire [PINS-1:0] out_d;
  wire [PINS-1:0] oe_d;
  reg  [31:0]     rd_d;

  // address phase qualifier
  wire            take;

  // write strobes, one per writable register; the pin level sample has none
  wire            wr_latch;
  wire            wr_enable_control;
  wire            wr_select_low;
  wire            wr_select_high;
  wire            wr_tristate_low;
  wire            wr_tristate_high;
  wire            wr_open_drain;

  // select fields of all pins, low register in the low half
  wire [63:0]     osel_all;
  wire [63:0]     tsel_all;

  // only whole-word accesses; other sizes are accepted but land as a word
  assign take     = hsel & hready & (htrans == `HTRANS_NONSEQ | htrans == `HTRANS_SEQ);
  assign osel_all = {output_select_high_q, output_select_low_q};
  assign tsel_all = {tristate_select_high_q, tristate_select_low_q};

  ////////////////////////////////////////////////////////////////////////
  // per-pin output routing

  // each pin picks its own registers or the alternate source
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin
      // field for pin g sits at bits 2g:2g+1 of the low/high pair
      wire [1:0] osel = osel_all[2*g +: `SEL_FIELD_WIDTH];
      wire [1:0] tsel = tsel_all[2*g +: `SEL_FIELD_WIDTH];
      wire       val  = (osel == `SEL_OWN_LOGIC) ? output_latch_q[g] : alt_out[g];
      // a select field of 00 hands the pad to this bank's own registers
      wire       en   = (tsel == `SEL_OWN_LOGIC) ? output_enable_control_q[g] : alt_oe[g];
      // open drain: only a low is driven, a high releases the pad
      assign out_d[g] = open_drain_enable_q[g] ? 1'b0 : val;
      assign oe_d[g]  = open_drain_enable_q[g] ? (en & ~val) : en;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux

  // unmapped or unaligned offsets read as zero
  always @* begin
    case (haddr)
      `OFS_OUTPUT_LATCH:          rd_d = output_latch_q;
      `OFS_OUTPUT_ENABLE_CONTROL: rd_d = output_enable_control_q;
      `OFS_OUTPUT_SELECT_LOW:     rd_d = output_select_low_q;
      `OFS_OUTPUT_SELECT_HIGH:    rd_d = output_select_high_q;
      `OFS_TRISTATE_SELECT_LOW:   rd_d = tristate_select_low_q;
      `OFS_TRISTATE_SELECT_HIGH:  rd_d = tristate_select_high_q;
      `OFS_OPEN_DRAIN_ENABLE:     rd_d = open_drain_enable_q;
      `OFS_PIN_LEVEL_SAMPLE:      rd_d = sync2_q;
      default:                    rd_d = `RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: address phase and response

  // the address phase is kept for the write that follows in the data phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (ce) begin
      if (hready) begin
        // an unmapped write address simply matches no strobe below
        wr_pend_q <= take & hwrite;
        wr_addr_q <= haddr;
      end
    end
  end

  // read data is fixed at the address edge; a write still in its data
  // phase on that edge is not yet visible to this read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= `RST_WORD;
    end else if (ce) begin
      if (hready & take & ~hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // zero-wait slave with a fixed okay response, so no master ever stalls
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write strobes

  // write data arrives in the data phase, one cycle after the address
  // unaligned or unmapped addresses raise no strobe, so the write is lost
  assign wr_latch          = wr_pend_q & (wr_addr_q == `OFS_OUTPUT_LATCH);
  assign wr_enable_control = wr_pend_q & (wr_addr_q == `OFS_OUTPUT_ENABLE_CONTROL);
  assign wr_select_low     = wr_pend_q & (wr_addr_q == `OFS_OUTPUT_SELECT_LOW);
  assign wr_select_high    = wr_pend_q & (wr_addr_q == `OFS_OUTPUT_SELECT_HIGH);
  assign wr_tristate_low   = wr_pend_q & (wr_addr_q == `OFS_TRISTATE_SELECT_LOW);
  assign wr_tristate_high  = wr_pend_q & (wr_addr_q == `OFS_TRISTATE_SELECT_HIGH);
  assign wr_open_drain     = wr_pend_q & (wr_addr_q == `OFS_OPEN_DRAIN_ENABLE);

  ////////////////////////////////////////////////////////////////////////
  // register file

  // every register holds a whole word; hsize is not decoded
  // output latch: bit n is the level pin n drives
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      output_latch_q <= `RST_WORD;
    end else if (ce) begin
      if (wr_latch) begin
        output_latch_q <= hwdata;
      end
    end
  end

  // control bits cleared at reset: every pin starts as a receiver
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      output_enable_control_q <= `RST_WORD;
    end else if (ce) begin
      if (wr_enable_control) begin
        output_enable_control_q <= hwdata;
      end
    end
  end

  // output select, pins 0 to 15
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      output_select_low_q <= `RST_WORD;
    end else if (ce) begin
      if (wr_select_low) begin
        output_select_low_q <= hwdata;
      end
    end
  end

  // output select, pins 16 to 31
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      output_select_high_q <= `RST_WORD;
    end else if (ce) begin
      if (wr_select_high) begin
        output_select_high_q <= hwdata;
      end
    end
  end

  // three-state select, pins 0 to 15
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tristate_select_low_q <= `RST_WORD;
    end else if (ce) begin
      if (wr_tristate_low) begin
        tristate_select_low_q <= hwdata;
      end
    end
  end

  // three-state select, pins 16 to 31
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tristate_select_high_q <= `RST_WORD;
    end else if (ce) begin
      if (wr_tristate_high) begin
        tristate_select_high_q <= hwdata;
      end
    end
  end

  // open drain: software must keep it clear for plain push-pull use
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      open_drain_enable_q <= `RST_WORD;
    end else if (ce) begin
      if (wr_open_drain) begin
        open_drain_enable_q <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin input synchroniser

  // pin_in is asynchronous; nothing may read it before sync2_q
  // two stages against metastability; only sync2_q reads sync1_q
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= {PINS{1'b0}};
      sync2_q <= {PINS{1'b0}};
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad drivers

  // pin_oe high means the bank drives the pad
  // registered so the pads never see decode glitches; costs one cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= {PINS{1'b0}};
      pin_oe  <= {PINS{1'b0}};
    end else if (ce) begin
      pin_out <= out_d;
      pin_oe  <= oe_d;
    end
  end

endmodule // gpio_bank_pin_control
`default_nettype wire

// ### gpio_bank_map.vh
/*
  Register offsets, field layout and reset values for the GPIO bank.
  Assumes inclusion by the bank module only; definitions, no logic.
*/
`ifndef GPIO_BANK_MAP_VH
`define GPIO_BANK_MAP_VH

`define OFS_OUTPUT_LATCH          8'h00
`define OFS_OUTPUT_ENABLE_CONTROL 8'h04
`define OFS_OUTPUT_SELECT_LOW     8'h08
`define OFS_OUTPUT_SELECT_HIGH    8'h0C
`define OFS_TRISTATE_SELECT_LOW   8'h10
`define OFS_TRISTATE_SELECT_HIGH  8'h14
`define OFS_OPEN_DRAIN_ENABLE     8'h18
`define OFS_PIN_LEVEL_SAMPLE      8'h1C

`define SEL_FIELD_WIDTH 2
`define SEL_OWN_LOGIC   2'h0
`define RST_WORD        32'h00000000

`define HTRANS_NONSEQ   2'h2
`define HTRANS_SEQ      2'h3

`endif

// ### board_pads.sv
/* board pads model; assumes released pins take the board's level */
`timescale 1ns/1ps
`default_nettype none
module board_pads (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext,
  output wire logic [31:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // board_pads
`default_nettype wire

// ### gpio_bank_checker_sva.sv
/* bus and pin checks of the bank; assumes one slave, ce held high */
`timescale 1ns/1ps
`default_nettype none
module gpio_bank_checker #(parameter PINS = 32) (
  input wire logic clk, rst, ce, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata, hrdata,
  input wire logic [PINS-1:0] alt_out, alt_oe, pin_in, pin_out, pin_oe
);
  logic [7:0][31:0] m_q;
  logic wr_q;
  logic [2:0] wi_q;
  logic [31:0] rd_q;
  wire rd = hsel && htrans[1] && !hwrite && hready && ce;
  // own drive only while every select and open-drain bit is zero
  wire own = (m_q[2] | m_q[3] | m_q[4] | m_q[5] | m_q[6]) == 32'h0;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      m_q <= '0;
      wr_q <= 1'b0;
      wi_q <= 3'h0;
      rd_q <= 32'h0;
    end else if (ce && hready) begin
      wr_q <= hsel && htrans[1] && hwrite && haddr[7:5] == 3'h0;
      wi_q <= haddr[4:2];
      if (wr_q && wi_q != 3'h7) m_q[wi_q] <= hwdata;
      if (rd) rd_q <= m_q[haddr[4:2]];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_PINS: assert property ($fell(rst) |-> pin_oe == 0 && pin_out == 0)
    else $error("pins not released after reset");
  AST_REG_READ: assert property (rd && haddr < 8'h1C && haddr[1:0] == 2'h0 |=> hrdata == rd_q)
    else $error("register readback wrong");
  AST_SAMPLE: assert property ($stable(pin_in)[*3] ##0 (rd && haddr == 8'h1C)
    |=> hrdata == $past(pin_in)) else $error("pin sample wrong");
  AST_OE: assert property (own |=> pin_oe == $past(m_q[1]))
    else $error("output enable wrong");
  AST_OUT: assert property (own |=> ((pin_out ^ $past(m_q[0])) & pin_oe) == 0)
    else $error("driven level wrong");
  AST_ALT_LOW: assert property (m_q[2][1:0] != 0 && !m_q[6][0] |=> pin_out[0] == $past(alt_out[0]))
    else $error("low select ignored");
  AST_ALT_HIGH: assert property (m_q[3][1:0] != 0 && !m_q[6][16] |=> pin_out[16] == $past(alt_out[16]))
    else $error("high select ignored");
  AST_ALT_OE: assert property (m_q[4][1:0] != 0 && !m_q[6][0] |=> pin_oe[0] == $past(alt_oe[0]))
    else $error("tristate select ignored");
  COV_DRIVE: cover property (own && pin_oe != 0);
  COV_ALT: cover property (m_q[2][1:0] != 0);
  COV_SAMPLE: cover property (rd && haddr == 8'h1C);
endmodule // gpio_bank_checker
bind gpio_bank_pin_control gpio_bank_checker #(.PINS(PINS)) chk (.clk(clk), .rst(rst), .ce(ce),
  .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
  .alt_out(alt_out), .alt_oe(alt_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ### tb.sv
/* bank bench; assumes zero-wait slave and pads model on the pins */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, r, ext = 32'h12345678, alt_out = 32'h0, alt_oe = 32'h0;
  logic [31:0] pin_in, pin_out, pin_oe, pin_oe2;
  int miscompares = 0, comparisons = 0, cyc = 0;
  always #50 clk = ~clk;
  gpio_bank_pin_control #(.PINS(32)) dut (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .alt_out(alt_out), .alt_oe(alt_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  board_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  // second bank: never selected, so it must stay released whatever the first does
  gpio_bank_pin_control #(.PINS(32)) dut2 (.clk(clk), .rst(rst), .ce(1'b1), .hsel(1'b0),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(), .alt_out(32'h0),
    .alt_oe(32'h0), .pin_in(ext), .pin_out(), .pin_oe(pin_oe2));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task pins(input logic [31:0] oe, input logic [31:0] out);
    repeat (2) @(posedge clk);
    chk(pin_oe, oe);
    chk(pin_out & oe, out);
  endtask
  task conclude;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 3000) begin miscompares++; conclude; end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk(pin_oe, 32'h0);
    for (int i = 0; i < 7; i++) begin bus(0, 8'(i * 4), 32'h0); chk(r, 32'h0); end
    $display("reset test done");
    bus(1, 8'h18, 32'h0);
    bus(1, 8'h00, 32'h80008001);
    bus(1, 8'h04, 32'hC0018001);
    pins(32'hC0018001, 32'h80008001);
    chk(pin_oe2, 32'h0);
    bus(0, 8'h1C, 32'h0);
    chk(r, 32'h80008001 | (ext & ~32'hC0018001));
    chk({30'h0, hreadyout, hresp}, 32'h2);
    bus(1, 8'h04, 32'h0);
    pins(32'h0, 32'h0);
    bus(0, 8'h1C, 32'h0);
    chk(r, ext);
    $display("drive test done");
    alt_out <= 32'h00010001;
    alt_oe <= 32'h1;
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h08, 32'h1);
    bus(1, 8'h0C, 32'h1);
    bus(1, 8'h10, 32'h1);
    pins(32'h1, 32'h1);
    chk(pin_out & 32'h00010001, 32'h00010001);
    bus(1, 8'h20, 32'hFFFFFFFF);
    bus(0, 8'h20, 32'h0);
    chk(r, 32'h0);
    $display("select test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pin_oe, 32'h0);
    rst <= 1'b0;
    bus(0, 8'h04, 32'h0);
    chk(r, 32'h0);
    $display("second reset test done");
    conclude;
  end
endmodule // tb
`default_nettype wire
